/* hdl/fcsb_bank.sv */
// FEC control, status and error update selection register bank
`timescale 1ns/100ps

// What this block does
// RULE1 - Flag one enables, zero disables; b0, b1
// RULE2 - Weight satellite streams only while b2 set
// RULE3 - Bit b4: satellite format, offset binary when one
// RULE4 - Bit b3: ground format, offset binary when one
// RULE5 - Host keeps both format bits equal
// RULE6 - Bit b5 flushes decoder per prime rate packet end
// RULE7 - Status flag one while sub-module active
// RULE8 - Status b3 prep, b2 RS, b1 decoder, b0 management
// RULE9 - Selection 0x00 overwrites errors every packet
// RULE10 - Selection 0x01/0x02 updates on control channels
// RULE11 - Selection 0x03..0x32 updates at packet value-2
// RULE12 - Host never programs selection above 0x32
module fcsb_bank
	import fcsb_pkg::*;
#(
	parameter int ERR_W = 8
)(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	// Enables and formats to the FEC sub-modules
	output logic fec_enable,
	output logic prep_enable,
	output logic terr_format,
	output logic sat_format,
	// Activity reported by the FEC sub-modules
	input wire logic act_prep,
	input wire logic act_rs_input,
	input wire logic act_decoder,
	input wire logic act_mgmt,
	// Packet events from the packet processor
	input wire logic packet_end,
	input wire logic [1:0] packet_kind,
	input wire logic [ERR_W-1:0] packet_errors,
	output logic decoder_flush,
	output logic [ERR_W-1:0] fec_errors,
	// Satellite soft data in
	input wire logic sat_valid,
	output logic sat_ready,
	input wire logic [SOFT_W-1:0] sat1_soft,
	input wire logic [SOFT_W-1:0] sat2_soft,
	input wire logic [WEIGHT_W-1:0] sat1_weight,
	input wire logic [WEIGHT_W-1:0] sat2_weight,
	// Weighted satellite data out
	output logic out_valid,
	input wire logic out_ready,
	output logic [2*SOFT_W-1:0] out_data
);
	localparam int FW = 2 * SOFT_W;

	// ==========================================================
	// Register state
	logic [CTRL_W-1:0] enable_control; // Control flags
	logic [SEL_W-1:0] error_update_select; // Error update mode
	logic [STAT_W-1:0] activity; // Live sub-module status
	logic [SEL_W-1:0] after_cc_count; // Prime rate packets since control channels
	logic wr_hit_ctrl;
	logic wr_hit_sel;
	logic err_take; // Copy errors this cycle

	assign wr_hit_ctrl = reg_wr && (reg_addr == OFS_ENABLE_CONTROL);
	assign wr_hit_sel = reg_wr && (reg_addr == OFS_ERROR_UPDATE_SELECT);

	// ==========================================================
	// Control register, reset to all enabled
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			enable_control <= RST_ENABLE_CONTROL;
		end
		else if (ce && wr_hit_ctrl)
		begin
			enable_control <= reg_wdata[CTRL_W-1:0];
		end
	end

	// Flags drive the sub-modules directly; one enables, zero disables
	assign fec_enable = enable_control[BIT_FEC_EN]; // see RULE1
	assign prep_enable = enable_control[BIT_PREP_EN]; // see RULE1
	// Format bits pass as stored; keeping them equal is the host's job
	assign terr_format = enable_control[BIT_TERR_FORMAT]; // see RULE4
	assign sat_format = enable_control[BIT_SAT_FORMAT]; // see RULE3 RULE5

	// ==========================================================
	// Error update selection register
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			error_update_select <= RST_ERROR_UPDATE_SELECT;
		end
		else if (ce && wr_hit_sel)
		begin
			error_update_select <= reg_wdata[SEL_W-1:0];
		end
	end

	// ==========================================================
	// Activity vector; sub-modules share this clock so no synchroniser
	always_comb
	begin
		activity = '0;
		activity[BIT_ACT_PREP] = act_prep; // see RULE8
		activity[BIT_ACT_RS_INPUT] = act_rs_input; // see RULE8
		activity[BIT_ACT_DECODER] = act_decoder; // see RULE8
		activity[BIT_ACT_MGMT] = act_mgmt; // see RULE8
	end

	// ==========================================================
	// Read data, registered; unmapped addresses read zero
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			reg_rdata <= '0;
		end
		else if (ce && reg_rd)
		begin
			unique case (reg_addr)
				OFS_ENABLE_CONTROL:
				begin
					reg_rdata <= DATA_W'(enable_control);
				end
				OFS_SUBMODULE_ACTIVITY:
				begin
					reg_rdata <= DATA_W'(activity); // see RULE7
				end
				OFS_ERROR_UPDATE_SELECT:
				begin
					reg_rdata <= DATA_W'(error_update_select);
				end
				default:
				begin
					reg_rdata <= '0;
				end
			endcase
		end
	end

	// ==========================================================
	// Decoder flush request, one cycle per prime rate packet end when enabled
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			decoder_flush <= 1'b0;
		end
		else if (ce)
		begin
			decoder_flush <= packet_end && (packet_kind == fcsb_pkt_prime) && enable_control[BIT_FLUSH_EN]; // see RULE6
		end
	end

	// ==========================================================
	// Count prime rate packets after the control channels
	// The count restarts at either control channel and saturates
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			after_cc_count <= '0;
		end
		else if (ce && packet_end)
		begin
			if (packet_kind == fcsb_pkt_first_cc || packet_kind == fcsb_pkt_second_cc)
			begin
				after_cc_count <= '0;
			end
			else if (after_cc_count != '1)
			begin
				after_cc_count <= after_cc_count + 1'b1;
			end
		end
	end

	// ==========================================================
	// Choose whether this packet's errors are captured
	always_comb
	begin
		err_take = 1'b0;
		if (packet_end)
		begin
			if (error_update_select == SEL_ASYNC)
			begin
				err_take = 1'b1; // see RULE9
			end
			else if (error_update_select == SEL_FIRST_CC)
			begin
				err_take = (packet_kind == fcsb_pkt_first_cc); // see RULE10
			end
			else if (error_update_select == SEL_SECOND_CC)
			begin
				err_take = (packet_kind == fcsb_pkt_second_cc); // see RULE10
			end
			else if (error_update_select <= SEL_NTH_HI)
			begin
				// Nth packet, counter holds N-1 before this one
				err_take = (packet_kind == fcsb_pkt_prime) &&
					(after_cc_count + 1'b1 == error_update_select - SEL_NTH_OFFSET); // see RULE11
			end
			// Codes above the defined range leave the errors alone
		end
	end

	// Error register capture
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			fec_errors <= '0;
		end
		else if (ce && err_take)
		begin
			fec_errors <= packet_errors;
		end
	end

	// ==========================================================
	// Satellite weighting ahead of the FIFO
	// Products keep the upper half so the word width stays fixed
	fcsb_fifo_if #(.WIDTH(FW)) fifo_in ();
	fcsb_fifo_if #(.WIDTH(FW)) fifo_out ();
	logic [SOFT_W+WEIGHT_W-1:0] prod1;
	logic [SOFT_W+WEIGHT_W-1:0] prod2;
	logic [FW-1:0] out_word;

	assign prod1 = sat1_soft * sat1_weight;
	assign prod2 = sat2_soft * sat2_weight;
	assign fifo_in.valid = sat_valid && fec_enable;
	// Weighted only while enabled, else soft data pass untouched
	assign fifo_in.data = enable_control[BIT_WGT_EN] ?
		{prod2[SOFT_W+WEIGHT_W-1 -: SOFT_W], prod1[SOFT_W+WEIGHT_W-1 -: SOFT_W]} :
		{sat2_soft, sat1_soft}; // see RULE2
	// Back-pressure from the FIFO stalls the source
	assign sat_ready = fifo_in.ready && fec_enable;

	fcsb_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.wr(fifo_in),
		.rd(fifo_out)
	);

	// ==========================================================
	// Output register stage so data leaves from flip-flops
	logic out_full;
	assign fifo_out.ready = !out_full || out_ready;
	assign out_valid = out_full;
	assign out_data = out_word;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_full <= 1'b0;
			out_word <= '0;
		end
		else if (ce)
		begin
			if (fifo_out.ready)
			begin
				out_full <= fifo_out.valid;
				if (fifo_out.valid)
				begin
					out_word <= fifo_out.data;
				end
			end
		end
	end
endmodule

/* hdl/fcsb_pkg.sv */
// Package of offsets, field positions, reset values and codes for the FEC control and status bank
package fcsb_pkg;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_CONTROL = 10'h300;
	localparam logic [ADDR_W-1:0] OFS_SUBMODULE_ACTIVITY = 10'h301;
	localparam logic [ADDR_W-1:0] OFS_ERROR_UPDATE_SELECT = 10'h302;

	// ==========================================================
	// Reset values and widths
	localparam int CTRL_W = 6;
	localparam int STAT_W = 4;
	localparam int SEL_W = 6;
	localparam logic [CTRL_W-1:0] RST_ENABLE_CONTROL = 6'h3f;
	localparam logic [SEL_W-1:0] RST_ERROR_UPDATE_SELECT = 6'h01;

	// ==========================================================
	// Control field positions
	localparam int BIT_FEC_EN = 0;
	localparam int BIT_PREP_EN = 1;
	localparam int BIT_WGT_EN = 2;
	localparam int BIT_TERR_FORMAT = 3;
	localparam int BIT_SAT_FORMAT = 4;
	localparam int BIT_FLUSH_EN = 5;

	// ==========================================================
	// Status field positions
	localparam int BIT_ACT_MGMT = 0;
	localparam int BIT_ACT_DECODER = 1;
	localparam int BIT_ACT_RS_INPUT = 2;
	localparam int BIT_ACT_PREP = 3;

	// ==========================================================
	// Error update selection codes
	localparam logic [SEL_W-1:0] SEL_ASYNC = 6'h00;
	localparam logic [SEL_W-1:0] SEL_FIRST_CC = 6'h01;
	localparam logic [SEL_W-1:0] SEL_SECOND_CC = 6'h02;
	localparam logic [SEL_W-1:0] SEL_NTH_LO = 6'h03;
	localparam logic [SEL_W-1:0] SEL_NTH_HI = 6'h32;
	localparam logic [SEL_W-1:0] SEL_NTH_OFFSET = 6'h02;

	// Kind of packet reported by the packet processor
	typedef enum logic [1:0] {
		fcsb_pkt_prime,
		fcsb_pkt_first_cc,
		fcsb_pkt_second_cc
	} fcsb_pkt_e;

	// ==========================================================
	// Data path
	localparam int SOFT_W = 4;
	localparam int WEIGHT_W = 4;
	localparam int FIFO_DEPTH = 8;

endpackage

/* hdl/fcsb_fifo_if.sv */
// Interface carrying a valid/ready word stream between bank modules
`timescale 1ns/100ps

interface fcsb_fifo_if #(parameter int WIDTH = 8);
	logic valid; // Word offered
	logic ready; // Word accepted
	logic [WIDTH-1:0] data; // Word itself
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

/* hdl/fcsb_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps

module fcsb_fifo
	import fcsb_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = FIFO_DEPTH
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Streams
	fcsb_fifo_if.sink wr,
	fcsb_fifo_if.source rd
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Word storage
	logic [PW-1:0] wptr; // Write position
	logic [PW-1:0] rptr; // Read position
	logic [PW:0] count; // Words held
	logic push;
	logic pop;

	// Full and empty come straight from the count
	assign wr.ready = (count != (PW+1)'(DEPTH));
	assign rd.valid = (count != '0);
	assign rd.data = mem[rptr];
	assign push = ce && wr.valid && wr.ready;
	assign pop = ce && rd.valid && rd.ready;

	// ==========================================================
	// Storage write, no reset needed on data
	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wptr] <= wr.data;
		end
	end

	// ==========================================================
	// Pointers and occupancy
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
			begin
				wptr <= (wptr == PW'(DEPTH-1)) ? '0 : wptr + 1'b1;
			end
			if (pop)
			begin
				rptr <= (rptr == PW'(DEPTH-1)) ? '0 : rptr + 1'b1;
			end
			if (push && !pop)
			begin
				count <= count + 1'b1;
			end
			else if (pop && !push)
			begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

/* test/fcsb_bank_asserts.sv */
// Concurrent checks on the ports of the FEC control and status bank
`timescale 1ns/100ps

module fcsb_bank_chk
	import fcsb_pkg::*;
#(
	parameter int ERR_W = 8
)(
	// Clock and reset
	input logic mclk,
	input logic rstn,
	input logic ce,
	// Register port
	input logic [ADDR_W-1:0] reg_addr,
	input logic reg_wr,
	input logic reg_rd,
	input logic [DATA_W-1:0] reg_wdata,
	input logic [DATA_W-1:0] reg_rdata,
	// Sub-module side
	input logic fec_enable,
	input logic prep_enable,
	input logic terr_format,
	input logic sat_format,
	input logic act_prep,
	input logic act_rs_input,
	input logic act_decoder,
	input logic act_mgmt,
	// Packet events and data gate
	input logic packet_end,
	input logic [1:0] packet_kind,
	input logic decoder_flush,
	input logic [ERR_W-1:0] fec_errors,
	input logic sat_ready
);
	// ==========================================================
	// Helpers
	logic [3:0] act_v; // Status as it should read
	assign act_v = {act_prep, act_rs_input, act_decoder, act_mgmt};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Accepted write to the control register
	sequence s_ctrl_wr;
		ce && reg_wr && reg_addr == OFS_ENABLE_CONTROL;
	endsequence
	// Accepted packet event
	sequence s_pkt;
		ce && packet_end;
	endsequence

	// ==========================================================
	// Assertions
	chk_ctrl_write: assert property (s_ctrl_wr |=> {sat_format, terr_format, prep_enable, fec_enable} ==
		{$past(reg_wdata[BIT_SAT_FORMAT]), $past(reg_wdata[BIT_TERR_FORMAT]), $past(reg_wdata[BIT_PREP_EN]),
		$past(reg_wdata[BIT_FEC_EN])})
		else $error("control outputs differ from written value");
	chk_ctrl_hold: assert property (!(ce && reg_wr && reg_addr == OFS_ENABLE_CONTROL) |=>
		$stable({sat_format, terr_format, prep_enable, fec_enable}))
		else $error("control outputs moved without a write");
	chk_status_read: assert property (ce && reg_rd && reg_addr == OFS_SUBMODULE_ACTIVITY |=> reg_rdata == {4'h0, $past(act_v)})
		else $error("status read differs from activity");
	chk_unmapped_zero: assert property (ce && reg_rd && (reg_addr < OFS_ENABLE_CONTROL || reg_addr > OFS_ERROR_UPDATE_SELECT) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_flush_cause: assert property (decoder_flush |-> $past(packet_end) && $past(ce) && $past(packet_kind) == 2'h0)
		else $error("flush without a prime packet");
	chk_flush_kind: assert property (s_pkt ##0 packet_kind != 2'h0 |=> !decoder_flush)
		else $error("flush on a control channel");
	chk_err_hold: assert property (!(ce && packet_end) |=> $stable(fec_errors))
		else $error("error value moved without a packet");
	chk_sat_gate: assert property (!fec_enable |-> !sat_ready)
		else $error("data accepted while correction disabled");
endmodule

bind fcsb_bank fcsb_bank_chk #(.ERR_W(ERR_W)) u_chk (.*);

/* test/fcsb_fec_model.sv */
// Behavioural model of the FEC sub-modules and the packet processor
`timescale 1ns/100ps

module fcsb_fec_model #(
	parameter int ERR_W = 8
)(
	// Clock
	input logic mclk,
	// Activity levels
	output logic act_prep,
	output logic act_rs_input,
	output logic act_decoder,
	output logic act_mgmt,
	// Packet events
	output logic packet_end,
	output logic [1:0] packet_kind,
	output logic [ERR_W-1:0] packet_errors
);
	// ==========================================================
	// Idle at time zero, qualifiers scrambled
	initial
	begin
		{act_prep, act_rs_input, act_decoder, act_mgmt} = 4'h0;
		packet_end = 1'b0;
		packet_kind = 2'h3;
		packet_errors = '1;
	end
	// Change activity just after an edge
	task set_act(input logic [3:0] a);
		@(posedge mclk);
		#1;
		{act_prep, act_rs_input, act_decoder, act_mgmt} = a;
	endtask
	// One packet; released qualifiers are inverted so a stale value never repeats the last one
	task pkt(input logic [1:0] kind, input logic [ERR_W-1:0] err);
		@(posedge mclk);
		#1;
		packet_end = 1'b1;
		packet_kind = kind;
		packet_errors = err;
		@(posedge mclk);
		#1;
		packet_end = 1'b0;
		packet_kind = ~kind;
		packet_errors = ~err;
	endtask
endmodule

/* test/fcsb_bank_tb.sv */
// Self-checking testbench of the FEC control and status bank
`timescale 1ns/100ps

module fcsb_bank_tb
	import fcsb_pkg::*;
;
	logic mclk, rstn, ce, reg_wr, reg_rd, sat_valid, sat_ready, out_valid, out_ready;
	logic fec_enable, prep_enable, terr_format, sat_format, decoder_flush, packet_end;
	logic act_prep, act_rs_input, act_decoder, act_mgmt;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, d, e, xe;
	logic [1:0] packet_kind, k;
	logic [7:0] packet_errors, fec_errors, out_data;
	logic [SOFT_W-1:0] sat1_soft, sat2_soft;
	logic [WEIGHT_W-1:0] sat1_weight, sat2_weight;
	logic [5:0] v, sel;
	logic [5:0] sels [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h10, 6'h32, 6'h05}; // Defined codes only
	logic f, w;
	logic [7:0] q [$];
	int n_fail, total_checks, cyc, cnt, i, j, n;

	fcsb_bank dut (.*);
	fcsb_fec_model fe (.*);

	// ==========================================================
	// Clock and hang guard
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			close_out;
		end
	end

	// ==========================================================
	// Helpers
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Register access, one idle cycle between accesses
	task wr(input logic [9:0] a, input logic [7:0] dv);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = dv;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~dv;
	endtask
	task rd(input logic [9:0] a, output logic [7:0] dv);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		dv = reg_rdata;
	endtask
	// Upper half of the product when weighting is on
	function automatic logic [3:0] wgt(input logic [3:0] s, input logic [3:0] g, input logic on);
		logic [7:0] p;
		p = s * g;
		return on ? p[7:4] : s;
	endfunction
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{ce, rstn, reg_wr, reg_rd, sat_valid, out_ready} = 6'h20;
		{reg_addr, reg_wdata, sat1_soft, sat2_soft, sat1_weight, sat2_weight} = '0;
		{n_fail, total_checks, cyc, cnt} = '0;
		xe = 8'h00;
		void'($urandom(51719));
		repeat (6) @(posedge mclk);
		#1;
		rstn = 1'b1;
		chk("ctrl reset", {fec_enable, prep_enable, terr_format, sat_format}, 4'hf);
		rd(OFS_ERROR_UPDATE_SELECT, d);
		chk("select reset", d, 8'h01);
		// Control flags, all clear and all set first
		for (i = 0; i < 10; i++)
		begin
			v = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
			v[4] = v[3]; // Host keeps both formats equal
			wr(OFS_ENABLE_CONTROL, {2'h0, v});
			chk("ctrl out", {fec_enable, prep_enable, terr_format, sat_format}, {v[0], v[1], v[3], v[4]});
			chk("ready gate", sat_ready, v[0]);
			rd(OFS_ENABLE_CONTROL, d);
			chk("ctrl read", d, {2'h0, v});
		end
		// Status and unmapped reads
		for (i = 0; i < 6; i++)
		begin
			v = 6'($urandom);
			fe.set_act(v[3:0]);
			rd(OFS_SUBMODULE_ACTIVITY, d);
			chk("status", d, {4'h0, v[3:0]});
		end
		rd(10'h303, d);
		chk("unmapped", d, 8'h00);
		// Flush and error update for every selection kind
		for (i = 0; i < 8; i++)
		begin
			sel = sels[i];
			f = 1'($urandom);
			wr(OFS_ENABLE_CONTROL, {2'h0, f, 5'h1f});
			wr(OFS_ERROR_UPDATE_SELECT, {2'h0, sel});
			for (j = 0; j < 60; j++)
			begin
				k = (j == 0 || (sel < 6'h20 && $urandom % 8 == 0)) ? 2'(1 + $urandom % 2) : 2'h0;
				e = 8'($urandom);
				fe.pkt(k, e);
				if (k != 2'h0)
					cnt = 0;
				else if (cnt < 63)
					cnt++;
				if (sel == 6'h00 || (k != 2'h0 && sel == 6'(k)) || (k == 2'h0 && sel >= 6'h03 && sel <= 6'h32 && cnt == sel - 2))
					xe = e;
				chk("flush", decoder_flush, f && k == 2'h0);
				chk("errors", fec_errors, xe);
			end
		end
		// Fill the buffer until refused, then drain with stalls; weighting off, then on
		for (j = 0; j < 2; j++)
		begin
			w = j[0];
			out_ready = 1'b0;
			wr(OFS_ENABLE_CONTROL, {2'h0, 3'h3, w, 2'h3});
			n = 0;
			sat_valid = 1'b1;
			{sat1_soft, sat2_soft, sat1_weight, sat2_weight} = 16'($urandom);
			repeat (12)
			begin
				// An offered word stands until it is taken
				#7;
				f = sat_ready;
				if (f)
				begin
					q.push_back({wgt(sat2_soft, sat2_weight, w), wgt(sat1_soft, sat1_weight, w)});
					n++;
				end
				@(posedge mclk);
				#1;
				if (f)
					{sat1_soft, sat2_soft, sat1_weight, sat2_weight} = 16'($urandom);
			end
			sat_valid = 1'b0;
			chk("accepted", 16'(n), 16'(FIFO_DEPTH + 1));
			for (i = 0; i < 200 && q.size() > 0; i++)
			begin
				out_ready = 1'($urandom);
				#7;
				if (out_valid && out_ready)
					chk("out data", out_data, q.pop_front());
				@(posedge mclk);
				#1;
			end
			chk("drained", 16'(q.size()), 16'h0);
		end
		// A frozen clock enable ignores a write; a mid-run reset restores defaults
		ce = 1'b0;
		wr(OFS_ENABLE_CONTROL, 8'h00);
		chk("frozen ctrl", {fec_enable, prep_enable, terr_format, sat_format}, 4'hf);
		ce = 1'b1;
		wr(OFS_ENABLE_CONTROL, 8'h00);
		chk("ctrl cleared", {fec_enable, prep_enable, terr_format, sat_format}, 4'h0);
		wr(OFS_ERROR_UPDATE_SELECT, 8'h10);
		rstn = 1'b0;
		@(posedge mclk);
		#1;
		rstn = 1'b1;
		chk("ctrl re-reset", {fec_enable, prep_enable, terr_format, sat_format}, 4'hf);
		chk("errors re-reset", fec_errors, 8'h00);
		rd(OFS_ERROR_UPDATE_SELECT, d);
		chk("select re-reset", d, 8'h01);
		close_out;
	end
endmodule
